// >>> core/adcrp_pkg.sv
// package for the conversion result output port: widths, bit positions, mode constants, coding and state enums
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package adcrp_pkg;
	localparam int RESULT_W    = 12;
	localparam int LEAD_ZEROS  = 4;
	localparam int FRAME_BITS  = LEAD_ZEROS + RESULT_W;
	localparam int CNT_W       = 5;
	localparam int PIN_MSB     = 11;
	localparam int PIN_BIT10   = 10;
	localparam int PIN_SERIAL_RESULT_OUT   = 5;
	localparam int PIN_SCLK    = 4;
	localparam int PIN_RFS     = 3;
	localparam logic MODE_SERIAL   = 1'b0;
	localparam logic MODE_PARALLEL = 1'b1;
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;
	localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
	localparam logic [RESULT_W-1:0] OFFSET_FLIP = 12'h800;

	typedef enum logic {
		ADCRP_TWOS_COMP,
		ADCRP_STRAIGHT_BIN
	} adcrp_coding_t;

	typedef enum logic [1:0] {
		ADCRP_IDLE,
		ADCRP_SHIFT,
		ADCRP_DONE
	} adcrp_state_t;

	// data pin group: driven levels and their enables
	typedef struct packed {
		logic [RESULT_W-1:0] pin_out;
		logic [RESULT_W-1:0] pin_oe;
	} adcrp_pins_t;
endpackage
`default_nettype wire

// >>> core/adcrp_sync.sv
// two flip-flop synchroniser for pin inputs
// assumes the async reset is already released synchronously by the caller
`default_nettype none
module adcrp_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule
`default_nettype wire

// >>> core/adcrp_top.sv
// conversion result output port: parallel three-state bus or host-clocked serial frame
// assumes the result word arrives from same-clock converter logic; pins come from the board
// Notes on behaviour
// RULE1 - parallel: three-state pins, bit 11 is msb
// RULE2 - serial: host ties bits 11,10 pins low
// RULE3 - serial: host leaves bits 9..6 unconnected
// RULE4 - serial: bit 5 pin is serial output
// RULE5 - frame: four zeros then 12 result bits
// RULE6 - bits valid at sixteen falling clock edges
// RULE7 - coding fixed by variant parameter
// RULE8 - mode low serial, high parallel
// RULE9 - shift out on rising serial clock edges
// RULE10 - host drives frame sync for serial
// RULE11 - parallel outputs enabled only read and select low
// RULE12 - after sixteen bits ignore clock until sync
`default_nettype none
module adcrp_top
	import adcrp_pkg::*;
#(
	parameter adcrp_coding_t CODING = ADCRP_TWOS_COMP
) (
	input  wire logic                          clk,
	input  wire logic                          reset_n,
	input  wire logic [adcrp_pkg::RESULT_W-1:0] result,
	input  wire logic                          result_valid,
	input  wire logic                          mode_sel,
	input  wire logic                          read_n,
	input  wire logic                          chip_sel_n,
	input  wire logic [adcrp_pkg::RESULT_W-1:0] pin_in,
	output var  adcrp_pkg::adcrp_pins_t         pins,
	output var  logic                          frame_busy
);
	import adcrp_pkg::*;

	logic                rst_meta;
	logic                rst_n;
	logic [4:0]          sync_q;
	logic                mode_q;
	logic                rd_q;
	logic                cs_q;
	logic                sclk_q;
	logic                rfs_q;
	logic                sclk_prev;
	logic                rfs_prev;
	logic                sclk_rise;
	logic                rfs_fall;
	logic [RESULT_W-1:0] held;
	logic [RESULT_W-1:0] coded;
	logic [FRAME_BITS-1:0] shreg;
	logic [CNT_W-1:0]    bit_cnt;
	logic                ser_bit;
	logic                par_en;
	adcrp_state_t        state;
	logic [1:0]          settle;

	// reset asserts at once, releases through two flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// the five pins the logic reads (mode, read, select, serial clock, frame sync) cross into the clock domain here
	adcrp_sync #(
		.WIDTH(5)
	) u_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in ({mode_sel, read_n, chip_sel_n, pin_in[PIN_SCLK], pin_in[PIN_RFS]}),
		.sync_out (sync_q)
	);

	// synchronised pins; the two test-low pins are not read, host holds them low [RULE2]
	assign mode_q = sync_q[4]; // [RULE8]
	assign rd_q   = sync_q[3];
	assign cs_q   = sync_q[2];
	assign sclk_q = sync_q[1];
	assign rfs_q  = sync_q[0];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// synchroniser resets low; match it so no false frame sync follows reset
			sclk_prev <= 1'b0;
			rfs_prev  <= 1'b0;
		end else begin
			sclk_prev <= sclk_q;
			rfs_prev  <= rfs_q;
		end
	end

	assign sclk_rise = sclk_q & ~sclk_prev;
	assign rfs_fall  = ~rfs_q & rfs_prev;

	// variant coding: natural binary is the offset form of the two's complement core word
	always_comb begin
		if (CODING == ADCRP_STRAIGHT_BIN) begin
			coded = result ^ OFFSET_FLIP; // [RULE7]
		end else begin
			coded = result; // [RULE7]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			held <= '0;
		end else if (result_valid) begin
			held <= coded;
		end
	end

	// serial frame engine on host clock edges seen through the synchroniser
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state   <= ADCRP_IDLE;
			shreg   <= '0;
			bit_cnt <= CNT_ZERO;
		end else if (mode_q != MODE_SERIAL) begin
			// leaving serial mode drops any frame in progress
			state   <= ADCRP_IDLE;
			bit_cnt <= CNT_ZERO;
		end else if (rfs_fall) begin
			// frame sync from host starts a new word [RULE10]
			state   <= ADCRP_SHIFT;
			shreg   <= {{LEAD_ZEROS{1'b0}}, held}; // [RULE5]
			bit_cnt <= CNT_ZERO;
		end else begin
			case (state)
				ADCRP_IDLE: begin
				end
				ADCRP_SHIFT: begin
					if (sclk_rise) begin
						// next bit on rising edge, stable for the falling one [RULE9] [RULE6]
						shreg   <= {shreg[FRAME_BITS-2:0], 1'b0};
						bit_cnt <= cnt_inc(bit_cnt);
						if (bit_cnt == CNT_FULL - CNT_ONE) begin
							state <= ADCRP_DONE; // [RULE12]
						end
					end
				end
				ADCRP_DONE: begin
					// further clocks ignored until a new frame sync [RULE12]
				end
				default: begin
					state <= ADCRP_IDLE;
				end
			endcase
		end
	end

	// counter step kept at the counter width
	function automatic logic [CNT_W-1:0] cnt_inc(input logic [CNT_W-1:0] c);
		cnt_inc = c + CNT_ONE;
	endfunction

	// first bit is out from frame sync until first rising edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ser_bit <= 1'b0;
		end else if (mode_q == MODE_SERIAL && rfs_fall) begin
			ser_bit <= 1'b0; // [RULE5]
		end else if (state == ADCRP_SHIFT && sclk_rise && bit_cnt != CNT_FULL - CNT_ONE) begin
			ser_bit <= shreg[FRAME_BITS-2]; // [RULE9]
		end else if (state == ADCRP_SHIFT) begin
			ser_bit <= shreg[FRAME_BITS-1];
		end else if (state != ADCRP_SHIFT) begin
			ser_bit <= 1'b0;
		end
	end

	// read and select are both active low
	assign par_en = (mode_q == MODE_PARALLEL) && !rd_q && !cs_q; // [RULE11]

	// synchronised mode reads as serial until real pin levels arrive
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			settle <= 2'h0;
		end else begin
			settle <= {settle[0], 1'b1};
		end
	end

	// busy flag follows the frame engine one clock late
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_busy <= 1'b0;
		end else if (!settle[1]) begin
			frame_busy <= 1'b0;
		end else begin
			frame_busy <= (mode_q == MODE_SERIAL) && (state == ADCRP_SHIFT);
		end
	end

	// pin drivers from flip-flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pins <= '0;
		end else if (!settle[1]) begin
			// no pin is driven on a mode that is not yet known
			pins <= '0;
		end else begin
			if (mode_q == MODE_PARALLEL) begin
				pins.pin_out <= held; // [RULE1]
				pins.pin_oe  <= {RESULT_W{par_en}}; // [RULE1] [RULE11]
			end else begin
				// only the serial output pin drives; bits 9..6 float [RULE3]
				pins.pin_out            <= '0;
				pins.pin_oe             <= '0;
				pins.pin_out[PIN_SERIAL_RESULT_OUT] <= ser_bit; // [RULE4]
				pins.pin_oe[PIN_SERIAL_RESULT_OUT]  <= 1'b1; // [RULE4]
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/adcrp_host.sv
// host model: frame sync and serial clock, bits taken at falling clock edges
// assumes the bench calls its tasks one at a time
`default_nettype none
module adcrp_host (
	input  wire logic serial_result_out,
	output var  logic sclk,
	output var  logic receive_frame_sync
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sclk = 1'b1; // idles high, still between frames
		receive_frame_sync = 1'b1;
	end
	task automatic frame(output logic [15:0] w);
		// step off the bench clock edge so no pin moves on it
		#1 receive_frame_sync = 1'b0;
		for (int i = 0; i < 16; i++) begin
			#62.5 w = {w[14:0], serial_result_out};
			sclk = 1'b0;
			#62.5 sclk = 1'b1;
		end
		#62.5 receive_frame_sync = 1'b1;
	endtask
	task automatic spare(input int n);
		repeat (n) begin
			#62.5 sclk = 1'b0;
			#62.5 sclk = 1'b1;
		end
	endtask
endmodule
`default_nettype wire

// >>> tb/adcrp_top_monitor.sv
// checker: parallel enables and data, serial frame bits and busy
// assumes the host holds frame sync and serial clock high between frames
`default_nettype none
module adcrp_top_monitor
	import adcrp_pkg::*;
#(
	parameter adcrp_coding_t CODING = ADCRP_TWOS_COMP
) (
	input wire logic                           clk,
	input wire logic                           reset_n,
	input wire logic [adcrp_pkg::RESULT_W-1:0] result,
	input wire logic                           result_valid,
	input wire logic                           mode_sel,
	input wire logic                           read_n,
	input wire logic                           chip_sel_n,
	input wire logic [adcrp_pkg::RESULT_W-1:0] pin_in,
	input wire adcrp_pkg::adcrp_pins_t         pins,
	input wire logic                           frame_busy
);
	logic [RESULT_W-1:0] ref_word;
	logic [CNT_W-1:0]    cnt;
	logic                sclk_q;
	logic                rfs_q;
	logic                sbit;
	logic                par_on;
	assign par_on = mode_sel && !read_n && !chip_sel_n;
	assign sbit = (cnt < 5'h04) ? 1'b0 : ref_word[4'(5'h0f - cnt)];
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			ref_word <= '0;
		else if (result_valid)
			ref_word <= (CODING == ADCRP_STRAIGHT_BIN) ? result ^ OFFSET_FLIP : result;
	end
	// rising serial clock edges counted since frame sync fell
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_q <= 1'b1;
			rfs_q <= 1'b1;
			cnt <= CNT_FULL;
		end else begin
			sclk_q <= pin_in[PIN_SCLK];
			rfs_q <= pin_in[PIN_RFS];
			if (!mode_sel && rfs_q && !pin_in[PIN_RFS])
				cnt <= CNT_ZERO;
			else if (!mode_sel && !sclk_q && pin_in[PIN_SCLK] && cnt != CNT_FULL)
				cnt <= cnt + CNT_ONE;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_par_drive: assert property (par_on [*7] |-> pins.pin_oe == 12'hfff)
		else $error("parallel outputs not driven");
	a_par_float: assert property ((mode_sel && (read_n || chip_sel_n)) [*7] |-> pins.pin_oe == 12'h000)
		else $error("parallel outputs driven while unselected");
	a_par_value: assert property ((par_on && !result_valid) [*7] |-> pins.pin_out == ref_word)
		else $error("parallel word wrong");
	a_ser_pins: assert property (!mode_sel [*7] |-> pins.pin_oe[PIN_SERIAL_RESULT_OUT] && pins.pin_oe[11:10] == 2'b00 && pins.pin_oe[4:3] == 2'b00)
		else $error("serial pin directions wrong");
	a_ser_bits: assert property (!mode_sel && $fell(pin_in[PIN_SCLK]) && cnt != CNT_FULL |-> pins.pin_out[PIN_SERIAL_RESULT_OUT] == sbit)
		else $error("serial bit wrong");
	a_ser_after: assert property (!mode_sel && $fell(pin_in[PIN_SCLK]) && cnt == CNT_FULL |-> !pins.pin_out[PIN_SERIAL_RESULT_OUT])
		else $error("serial output not low after frame");
	a_busy_start: assert property (!mode_sel && $fell(pin_in[PIN_RFS]) |-> ##[1:8] frame_busy)
		else $error("frame not started");
	a_busy_end: assert property ((!mode_sel && cnt == CNT_FULL) [*8] |-> !frame_busy)
		else $error("frame busy after sixteen bits");
endmodule
bind adcrp_top adcrp_top_monitor #(.CODING(CODING)) i_adcrp_top_monitor (.clk(clk), .reset_n(reset_n), .result(result),
	.result_valid(result_valid), .mode_sel(mode_sel), .read_n(read_n), .chip_sel_n(chip_sel_n), .pin_in(pin_in),
	.pins(pins), .frame_busy(frame_busy));
`default_nettype wire

// >>> tb/adcrp_top_tb.sv
// bench: parallel reads over select combinations, serial frames through the host model
// assumes the package, the design and the host model are compiled first
`default_nettype none
module adcrp_top_tb
	import adcrp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic                clk = 1'b0;
	logic                reset_n = 1'b0;
	logic                result_valid = 1'b0;
	logic                mode_sel = 1'b1;
	logic                read_n = 1'b1;
	logic                chip_sel_n = 1'b1;
	logic [RESULT_W-1:0] result = '0;
	logic [RESULT_W-1:0] pin_in;
	adcrp_pins_t         pins;
	adcrp_pins_t         pins_twos;
	logic                frame_busy;
	logic                sclk;
	logic                receive_frame_sync;
	int                  err_count = 0;
	int                  checked = 0;
	always #2.5 clk = ~clk;
	// undriven pins float to the inverse of the last value
	assign pin_in = mode_sel ? ~(pins.pin_oe ^ pins.pin_out) : {2'b00, ~(pins.pin_oe[9:5] ^ pins.pin_out[9:5]), sclk, receive_frame_sync,
		~(pins.pin_oe[2:0] ^ pins.pin_out[2:0])};
	adcrp_top #(.CODING(ADCRP_STRAIGHT_BIN)) i_adcrp_top (.clk(clk), .reset_n(reset_n), .result(result),
		.result_valid(result_valid), .mode_sel(mode_sel), .read_n(read_n), .chip_sel_n(chip_sel_n),
		.pin_in(pin_in), .pins(pins), .frame_busy(frame_busy));
	// second variant: two's complement coding, checked in parallel and by its bound checker
	adcrp_top #(.CODING(ADCRP_TWOS_COMP)) i_adcrp_top_twos (.clk(clk), .reset_n(reset_n), .result(result),
		.result_valid(result_valid), .mode_sel(mode_sel), .read_n(read_n), .chip_sel_n(chip_sel_n),
		.pin_in(pin_in), .pins(pins_twos), .frame_busy());
	adcrp_host i_adcrp_host (.serial_result_out(pin_in[PIN_SERIAL_RESULT_OUT]), .sclk(sclk), .receive_frame_sync(receive_frame_sync));
	task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic load(input logic [11:0] v);
		@(posedge clk) result <= v;
		result_valid <= 1'b1;
		@(posedge clk) result_valid <= 1'b0;
	endtask
	task automatic t_parallel(input logic [11:0] v);
		@(posedge clk) mode_sel <= 1'b1;
		load(v);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk) {read_n, chip_sel_n} <= 2'(k);
			cyc(8);
			#1;
			chk("oe", (k == 0) ? 16'h0fff : 16'h0000, {4'h0, pins.pin_oe});
			if (k == 0) begin
				chk("word", {4'h0, v ^ OFFSET_FLIP}, {4'h0, pins.pin_out});
				chk("word_twos", {4'h0, v}, {4'h0, pins_twos.pin_out});
			end
		end
	endtask
	task automatic t_serial(input logic [11:0] v);
		logic [15:0] w;
		@(posedge clk) mode_sel <= 1'b0;
		load(v);
		cyc(8);
		i_adcrp_host.frame(w);
		chk("frame", {4'h0, v ^ OFFSET_FLIP}, w);
		i_adcrp_host.spare(3);
		chk("after", 16'h0000, {15'h0, pin_in[PIN_SERIAL_RESULT_OUT]});
		chk("busy", 16'h0000, {15'h0, frame_busy});
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		cyc(12);
		reset_n <= 1'b1;
		cyc(8);
		t_parallel(12'h9a5);
		t_serial(12'h3c6);
		t_serial(12'hfff);
		t_parallel(12'h07f);
		complete_run();
	end
endmodule
`default_nettype wire
